// *** rsc_cfg.svh ***
// rail sequencing control: register offsets, field positions, reset values, timing counts
// assumes a 25 MHz system clock and a 32-bit APB slave port
//
// Function
// - each rail waits its on/off delay, then ramps for its rise/fall time
// - time-based rails ramp independently and finish regardless of other rails
// - start/stop comes from the control pin or the operation command per rail
// - rails bound to the control pin all react on the same pin change
// - page 255 makes operation commands act on all rails together
// - in group mode commands are held and run at the bus stop condition
// - slave starts after master is in regulation; power-good drops at shutdown start
// - power-good output covers all rails by default, or a programmed subset
// - up to four sequencing inputs and eight sequencing outputs
// - each sequencing output is open-drain or driven, with selectable polarity
// - rail on/off depends on chosen rails' power-good and sequencing inputs
// - outputs show combined rail power-good or power-good, overcurrent, outputs-valid
// - a shutdown propagates to rails or controllers that depend on it
// - a rail fault shuts down any configured selection of other rails
// - an immediate-shutdown fault forces dependent rails off immediately too
// - after power-good, an input not at its level before timeout stops the rail
// - timeout enabled per rail with own value; one shared input pin is source
// - pins used for their primary function are not used for sequencing
// - fan-drive and indicator pins serve only as sequencing inputs
// - idle rails keep pulse-width and rectifier enables off
// - regulation comes turn-on delay plus rise time after the command, or up to one update tick sooner
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

`define RSC_RAILS 4
`define RSC_SEQ_IN 4
`define RSC_SEQ_OUT 8

// timing: ramp and delay counts are in 10 kHz update ticks
`define RSC_CLK_NS 40
`define RSC_TICK_NS 100000
`define RSC_TICK_CYC (`RSC_TICK_NS / `RSC_CLK_NS)

// register byte offsets
`define RSC_PAGE_ADDR 12'h000
`define RSC_OPER_ADDR 12'h004
`define RSC_ONOFF_ADDR 12'h008
`define RSC_CTRL_ADDR 12'h00C
`define RSC_PGMASK_ADDR 12'h010
`define RSC_STATUS_ADDR 12'h014
`define RSC_TIM_BASE 12'h040
`define RSC_DEP_BASE 12'h080
`define RSC_OUT_BASE 12'h0A0

// fields
`define RSC_PAGE_ALL 8'hFF
`define RSC_OP_ON_BIT 7
`define RSC_CTRL_GROUP 0
`define RSC_CTRL_LEVEL 3
`define RSC_DEP_TMO_EN 12
`define RSC_DEP_IMM 13
`define RSC_OUT_OD 6
`define RSC_OUT_INV 7
`define RSC_OUT_EN 8

// reset values
`define RSC_ONOFF_RST 8'hAA
`define RSC_PGMASK_RST 4'hF
`define RSC_CTRL_RST 4'h0

`endif

// *** rsc_peer.sv ***
// peer controller model: its rails come up a fixed delay after its run pin goes high
// assumes the testbench clock and reset; drives its power-good pin actively
`timescale 1ns/1ps
module rsc_peer #(
  parameter int DLY = 40
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // run pin and power-good pin
  input wire logic run_in,
  output logic pg_out
);
  int cnt;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt <= 0;
      pg_out <= 1'h0;
    end else if (!run_in) begin
      // drop at shutdown start so slaves never outlive their master
      cnt <= 0;
      pg_out <= 1'h0;
    end else if (cnt < DLY) begin
      cnt <= cnt + 1;
    end else begin
      pg_out <= 1'h1;
    end
  end
endmodule

// *** rsc_pkg.sv ***
// rail sequencing control: state types
// assumes rsc_cfg.svh on the include path
`include "rsc_cfg.svh"

package rsc_pkg;

  typedef enum logic [2:0] {
    RSC_OFF, RSC_ON_DLY, RSC_RISE, RSC_REG, RSC_OFF_DLY, RSC_FALL
  } rsc_rail_type;

  typedef struct packed {
    logic [1:0] ctl_sync;
    logic [`RSC_SEQ_IN-1:0] pin_s1;
    logic [`RSC_SEQ_IN-1:0] pin_s2;
    logic [7:0] page;
    logic [`RSC_RAILS-1:0] op_on;
    logic pend_v;
    logic pend_on;
    logic [7:0] pend_page;
    logic [7:0] onoff;
    logic [3:0] control;
    logic [`RSC_RAILS-1:0] pg_mask;
    logic [`RSC_RAILS-1:0][3:0][15:0] timing;
    logic [`RSC_RAILS-1:0][31:0] dep;
    logic [`RSC_SEQ_OUT-1:0][8:0] outcfg;
    rsc_rail_type [`RSC_RAILS-1:0] rail;
    logic [`RSC_RAILS-1:0][15:0] cnt;
    logic [`RSC_RAILS-1:0][15:0] tmo_cnt;
    logic [`RSC_RAILS-1:0] tmo_done;
    logic [`RSC_RAILS-1:0] faulted;
    logic [`RSC_RAILS-1:0] tmo_err;
    logic [11:0] tick;
    logic od_valid;
    logic [`RSC_RAILS-1:0] pwm_en;
    logic [`RSC_RAILS-1:0] sync_rectifier_enable;
    logic [`RSC_RAILS-1:0] rail_pg;
    logic pgood;
    logic [`RSC_SEQ_OUT-1:0] seq_o;
    logic [`RSC_SEQ_OUT-1:0] seq_oe;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } rsc_state_type;

endpackage

// *** rsc_rail_seq.sv ***
// rail sequencing control: per-rail delay/ramp sequencer, dependencies, fault
// cascade, input timeout supervision, sequencing outputs and APB registers
// assumes fault and warning inputs come from logic on sys_clk_in; pins are asynchronous
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "rsc_cfg.svh"

module rsc_rail_seq #(
  parameter bit SMALL_PKG = 1'b0
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // management bus engine
  input wire logic bus_stop_in,
  // pins
  input wire logic ctrl_pin_in,
  input wire logic [`RSC_SEQ_IN-1:0] seq_pin_in,
  input wire logic [`RSC_SEQ_OUT-1:0] pin_primary_in,
  // rail monitors
  input wire logic [`RSC_RAILS-1:0] fault_in,
  input wire logic [`RSC_RAILS-1:0] ocw_in,
  // rail drive and status
  output logic [`RSC_RAILS-1:0] pwm_en_out,
  output logic [`RSC_RAILS-1:0] sync_rectifier_enable_out,
  output logic [`RSC_RAILS-1:0] rail_pg_out,
  output logic pgood_out,
  output logic [`RSC_SEQ_OUT-1:0] seq_out,
  output logic [`RSC_SEQ_OUT-1:0] seq_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [11:0] TICK_LAST = 12'(`RSC_TICK_CYC - 1);

  rsc_pkg::rsc_state_type st;
  rsc_pkg::rsc_state_type nx;
  logic tick_p;
  logic wr_acc;
  logic [`RSC_RAILS-1:0] pg_now;
  logic [`RSC_RAILS-1:0] fimm;
  logic [`RSC_RAILS-1:0] trip;
  logic [`RSC_RAILS-1:0] onehot;
  logic [15:0] lim;
  logic [15:0] cnt_nx;
  logic ext_ok;
  logic dep_ok;
  logic on_req;
  logic soft_hit;
  logic imm_hit;
  logic tmo_pin_ok;
  logic src_v;
  logic [1:0] src_sel;

  function automatic logic rsc_mapped(input logic [11:0] a);
    rsc_mapped = (a[1:0] == 2'h0) && (a == `RSC_PAGE_ADDR || a == `RSC_OPER_ADDR ||
      a == `RSC_ONOFF_ADDR || a == `RSC_CTRL_ADDR || a == `RSC_PGMASK_ADDR ||
      a == `RSC_STATUS_ADDR || (a & 12'hFC0) == `RSC_TIM_BASE ||
      (a & 12'hFF0) == `RSC_DEP_BASE || (a & 12'hFE0) == `RSC_OUT_BASE);
  endfunction

  // page 255 hits every rail, a page beyond the rails hits none
  function automatic logic [`RSC_RAILS-1:0] rsc_apply(input logic [`RSC_RAILS-1:0] cur,
      input logic [7:0] pg, input logic on);
    rsc_apply = cur;
    for (int i = 0; i < `RSC_RAILS; i++) begin
      if (pg == `RSC_PAGE_ALL || pg == 8'(i)) begin
        rsc_apply[i] = on;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nx = st;
    lim = 16'h0000;
    cnt_nx = 16'h0000;
    ext_ok = 1'b0;
    dep_ok = 1'b0;
    on_req = 1'b0;
    soft_hit = 1'b0;
    imm_hit = 1'b0;
    onehot = '0;
    src_v = 1'b0;
    src_sel = 2'h0;
    // control and sequencing pins pass two flops before any decision reads them; pin_primary_in is read directly
    nx.ctl_sync = {st.ctl_sync[0], ctrl_pin_in};
    nx.pin_s1 = seq_pin_in;
    nx.pin_s2 = st.pin_s1;
    nx.od_valid = 1'b1;
    tick_p = (st.tick == TICK_LAST);
    nx.tick = tick_p ? 12'h000 : st.tick + 12'h001;
    tmo_pin_ok = (st.pin_s2[st.control[2:1]] == st.control[`RSC_CTRL_LEVEL]);

    // apb: one wait state, the write lands on the edge that samples pready
    wr_acc = psel_in && penable_in && pwrite_in && st.ready && rsc_mapped(paddr_in);
    nx.ready = psel_in && penable_in && !st.ready;
    nx.slverr = psel_in && penable_in && !st.ready && !rsc_mapped(paddr_in);
    nx.rdata = 32'h0000_0000;
    if (psel_in && penable_in && !st.ready) begin
      if (paddr_in == `RSC_PAGE_ADDR) begin
        nx.rdata = {24'h000000, st.page};
      end else if (paddr_in == `RSC_OPER_ADDR) begin
        nx.rdata = {24'h000000, (&(st.op_on | ~rsc_apply('0, st.page, 1'b1))), 7'h00};
      end else if (paddr_in == `RSC_ONOFF_ADDR) begin
        nx.rdata = {24'h000000, st.onoff};
      end else if (paddr_in == `RSC_CTRL_ADDR) begin
        nx.rdata = {28'h0000000, st.control};
      end else if (paddr_in == `RSC_PGMASK_ADDR) begin
        nx.rdata = {28'h0000000, st.pg_mask};
      end else if (paddr_in == `RSC_STATUS_ADDR) begin
        for (int r = 0; r < `RSC_RAILS; r++) begin
          nx.rdata[r] = (st.rail[r] == rsc_pkg::RSC_REG);
          nx.rdata[4 + r] = st.faulted[r];
          nx.rdata[8 + r] = st.tmo_err[r];
          nx.rdata[12 + r] = (st.rail[r] == rsc_pkg::RSC_RISE) ||
            (st.rail[r] == rsc_pkg::RSC_FALL);
        end
      end else if ((paddr_in & 12'hFC0) == `RSC_TIM_BASE) begin
        nx.rdata = {16'h0000, st.timing[paddr_in[5:4]][paddr_in[3:2]]};
      end else if ((paddr_in & 12'hFF0) == `RSC_DEP_BASE) begin
        nx.rdata = st.dep[paddr_in[3:2]];
      end else if ((paddr_in & 12'hFE0) == `RSC_OUT_BASE) begin
        nx.rdata = {23'h000000, st.outcfg[paddr_in[4:2]]};
      end
    end
    if (wr_acc) begin
      if (paddr_in == `RSC_PAGE_ADDR) begin
        nx.page = pwdata_in[7:0];
      end else if (paddr_in == `RSC_OPER_ADDR) begin
        if (st.control[`RSC_CTRL_GROUP]) begin
          // held until the stop closes the group transmission
          nx.pend_v = 1'b1;
          nx.pend_on = pwdata_in[`RSC_OP_ON_BIT];
          nx.pend_page = st.page;
        end else begin
          nx.op_on = rsc_apply(st.op_on, st.page, pwdata_in[`RSC_OP_ON_BIT]);
        end
      end else if (paddr_in == `RSC_ONOFF_ADDR) begin
        nx.onoff = pwdata_in[7:0];
      end else if (paddr_in == `RSC_CTRL_ADDR) begin
        nx.control = pwdata_in[3:0];
      end else if (paddr_in == `RSC_PGMASK_ADDR) begin
        nx.pg_mask = pwdata_in[`RSC_RAILS-1:0];
      end else if (paddr_in == `RSC_STATUS_ADDR) begin
        nx.tmo_err = st.tmo_err & ~pwdata_in[11:8];
      end else if ((paddr_in & 12'hFC0) == `RSC_TIM_BASE) begin
        nx.timing[paddr_in[5:4]][paddr_in[3:2]] = pwdata_in[15:0];
      end else if ((paddr_in & 12'hFF0) == `RSC_DEP_BASE) begin
        nx.dep[paddr_in[3:2]] = pwdata_in;
      end else begin
        nx.outcfg[paddr_in[4:2]] = pwdata_in[8:0];
      end
    end
    if (bus_stop_in && st.pend_v) begin
      nx.op_on = rsc_apply(st.op_on, st.pend_page, st.pend_on);
      // a group write in the stop cycle stays pending for the next stop
      if (!(wr_acc && paddr_in == `RSC_OPER_ADDR && st.control[`RSC_CTRL_GROUP])) begin
        nx.pend_v = 1'b0;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    for (int r = 0; r < `RSC_RAILS; r++) begin
      pg_now[r] = (st.rail[r] == rsc_pkg::RSC_REG);
      fimm[r] = fault_in[r] & st.dep[r][`RSC_DEP_IMM];
    end
    for (int r = 0; r < `RSC_RAILS; r++) begin
      onehot = 4'h1 << r;
      trip[r] = pg_now[r] && st.dep[r][`RSC_DEP_TMO_EN] && !st.tmo_done[r] &&
        !tmo_pin_ok && (st.tmo_cnt[r] >= st.dep[r][31:16]);
      soft_hit = fault_in[r] || (|(fault_in & st.dep[r][11:8])) || trip[r];
      imm_hit = |(fimm & (st.dep[r][11:8] | onehot));
      // a rail bound to the pin reacts on the same synchronised edge as all others
      ext_ok = (!st.onoff[2 * r] || st.ctl_sync[1]) &&
        (!st.onoff[2 * r + 1] || st.op_on[r]);
      dep_ok = (&(pg_now | ~st.dep[r][3:0])) && (&(st.pin_s2 | ~st.dep[r][7:4]));
      // a fault latches off until the rail is commanded off; a new fault wins the clear
      if (!ext_ok) begin
        nx.faulted[r] = 1'b0;
      end
      if (soft_hit || imm_hit) begin
        nx.faulted[r] = 1'b1;
      end
      // losing a dependency stops the rail, so shutdowns ripple down the chain
      on_req = ext_ok && dep_ok && !st.faulted[r] && !soft_hit;
      case (st.rail[r])
        rsc_pkg::RSC_ON_DLY: lim = st.timing[r][0];
        rsc_pkg::RSC_RISE: lim = st.timing[r][1];
        rsc_pkg::RSC_OFF_DLY: lim = st.timing[r][2];
        rsc_pkg::RSC_FALL: lim = st.timing[r][3];
        default: lim = 16'h0000;
      endcase
      cnt_nx = tick_p ? st.cnt[r] + 16'h0001 : st.cnt[r];
      // each rail runs on its own counters, unaware of the others' success
      case (st.rail[r])
        rsc_pkg::RSC_OFF: begin
          nx.cnt[r] = 16'h0000;
          if (on_req) begin
            nx.rail[r] = rsc_pkg::RSC_ON_DLY;
          end
        end
        rsc_pkg::RSC_ON_DLY: begin
          nx.cnt[r] = 16'h0000;
          if (!on_req) begin
            nx.rail[r] = rsc_pkg::RSC_OFF;
          end else if (st.cnt[r] >= lim) begin
            nx.rail[r] = rsc_pkg::RSC_RISE;
          end else begin
            nx.cnt[r] = cnt_nx;
          end
        end
        rsc_pkg::RSC_RISE: begin
          nx.cnt[r] = 16'h0000;
          if (!on_req) begin
            nx.rail[r] = rsc_pkg::RSC_OFF_DLY;
          end else if (st.cnt[r] >= lim) begin
            nx.rail[r] = rsc_pkg::RSC_REG;
          end else begin
            nx.cnt[r] = cnt_nx;
          end
        end
        rsc_pkg::RSC_REG: begin
          nx.cnt[r] = 16'h0000;
          if (!on_req) begin
            nx.rail[r] = rsc_pkg::RSC_OFF_DLY;
          end
        end
        rsc_pkg::RSC_OFF_DLY: begin
          nx.cnt[r] = 16'h0000;
          if (st.cnt[r] >= lim) begin
            nx.rail[r] = rsc_pkg::RSC_FALL;
          end else begin
            nx.cnt[r] = cnt_nx;
          end
        end
        rsc_pkg::RSC_FALL: begin
          nx.cnt[r] = 16'h0000;
          if (st.cnt[r] >= lim) begin
            nx.rail[r] = rsc_pkg::RSC_OFF;
          end else begin
            nx.cnt[r] = cnt_nx;
          end
        end
        default: begin
          nx.rail[r] = rsc_pkg::RSC_OFF;
          nx.cnt[r] = 16'h0000;
        end
      endcase
      if (imm_hit) begin
        nx.rail[r] = rsc_pkg::RSC_OFF;
        nx.cnt[r] = 16'h0000;
      end
      // timeout only runs while regulated; anything else rearms it
      if (!pg_now[r] || nx.rail[r] != rsc_pkg::RSC_REG) begin
        nx.tmo_cnt[r] = 16'h0000;
        nx.tmo_done[r] = 1'b0;
      end else if (st.dep[r][`RSC_DEP_TMO_EN] && !st.tmo_done[r]) begin
        if (tmo_pin_ok) begin
          nx.tmo_done[r] = 1'b1;
        end else if (tick_p) begin
          nx.tmo_cnt[r] = st.tmo_cnt[r] + 16'h0001;
        end
      end
      if (trip[r]) begin
        nx.tmo_err[r] = 1'b1;
      end
      // outputs follow the next state so power-good drops on the shutdown edge
      nx.pwm_en[r] = (nx.rail[r] != rsc_pkg::RSC_OFF) &&
        (nx.rail[r] != rsc_pkg::RSC_ON_DLY);
      nx.sync_rectifier_enable[r] = nx.pwm_en[r] &&
        (nx.rail[r] != rsc_pkg::RSC_FALL);
      nx.rail_pg[r] = (nx.rail[r] == rsc_pkg::RSC_REG);
    end
    nx.pgood = &(nx.rail_pg | ~st.pg_mask);

    ////////////////////////////////////////////////////////////////////////
    for (int n = 0; n < `RSC_SEQ_OUT; n++) begin
      src_sel = st.outcfg[n][5:4];
      case (src_sel)
        2'h0: src_v = &(nx.rail_pg | ~st.outcfg[n][3:0]);
        2'h1: src_v = nx.pgood;
        2'h2: src_v = |ocw_in;
        default: src_v = st.od_valid;
      endcase
      src_v = src_v ^ st.outcfg[n][`RSC_OUT_INV];
      // outputs 6 and 7 sit on pins the small package lacks; fan/indicator pins are inputs only
      if (st.outcfg[n][`RSC_OUT_EN] && !pin_primary_in[n] &&
          !(SMALL_PKG && n >= 6)) begin
        nx.seq_o[n] = st.outcfg[n][`RSC_OUT_OD] ? 1'b0 : src_v;
        nx.seq_oe[n] = st.outcfg[n][`RSC_OUT_OD] ? !src_v : 1'b1;
      end else begin
        nx.seq_o[n] = 1'b0;
        nx.seq_oe[n] = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= '0;
      st.onoff <= `RSC_ONOFF_RST;
      st.control <= `RSC_CTRL_RST;
      st.pg_mask <= `RSC_PGMASK_RST;
    end else begin
      st <= nx;
    end
  end

  assign prdata_out = st.rdata;
  assign pready_out = st.ready;
  assign pslverr_out = st.slverr;
  assign pwm_en_out = st.pwm_en;
  assign sync_rectifier_enable_out = st.sync_rectifier_enable;
  assign rail_pg_out = st.rail_pg;
  assign pgood_out = st.pgood;
  assign seq_out = st.seq_o;
  assign seq_oe_out = st.seq_oe;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  dly_wait_a: assert property (
    (st.rail[0] == rsc_pkg::RSC_ON_DLY && nx.rail[0] == rsc_pkg::RSC_RISE)
      |-> st.cnt[0] >= st.timing[0][0])
    else $error("rail left turn-on delay early");
  idle_quiet_a: assert property (
    (st.rail[0] == rsc_pkg::RSC_OFF) [*2] |->
      !pwm_en_out[0] && !sync_rectifier_enable_out[0])
    else $error("idle rail drives its enables");
  pg_follow_a: assert property (
    $fell(st.rail[0] == rsc_pkg::RSC_REG) |-> !rail_pg_out[0] ##1 !rail_pg_out[0])
    else $error("power-good held after shutdown start");
  pg_mask_a: assert property (
    pgood_out == &(rail_pg_out | ~$past(st.pg_mask)))
    else $error("power-good output ignores its mask");
  pin_sync_a: assert property (
    !$past(sys_rst_in) && !$past(sys_rst_in, 2) |-> st.pin_s2 == $past(seq_pin_in, 2))
    else $error("sequencing input not two flops deep");
  imm_stop_a: assert property (
    fault_in[1] && st.dep[1][`RSC_DEP_IMM] && st.dep[3][9] |=> st.rail[3] == rsc_pkg::RSC_OFF)
    else $error("dependent rail did not stop at once");
  tmo_clear_a: assert property (
    st.rail[0] != rsc_pkg::RSC_REG |=> st.tmo_cnt[0] == 16'h0000)
    else $error("timeout counter kept while off");
  tmo_trip_a: assert property (
    trip[0] |=> st.faulted[0] && st.tmo_err[0] ##1 st.rail[0] != rsc_pkg::RSC_REG)
    else $error("input timeout did not stop the rail");
  grp_hold_a: assert property (
    st.pend_v && st.control[`RSC_CTRL_GROUP] && !bus_stop_in |=> st.op_on == $past(st.op_on))
    else $error("group command ran before stop");

endmodule

// *** tb.sv ***
// testbench for the rail sequencing block: registers, ramps, pins, faults, outputs
// assumes rsc_peer models the peer on the control pin and on sequencing input 0
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic e;
  } rsc_row_type;
  typedef struct packed {
    logic [2:0] n;
    logic [8:0] c;
    logic p;
    logic o;
    logic [1:0] x;
  } rsc_out_type;
  localparam rsc_row_type ROWS [14] = '{
    '{1'h0, 12'h000, 32'h0, 32'h0, 1'h0},
    '{1'h0, 12'h008, 32'h0, 32'hAA, 1'h0},
    '{1'h0, 12'h00C, 32'h0, 32'h0, 1'h0},
    '{1'h0, 12'h010, 32'h0, 32'hF, 1'h0},
    '{1'h0, 12'h014, 32'h0, 32'h0, 1'h0},
    '{1'h1, 12'h040, 32'h2, 32'h0, 1'h0},
    '{1'h1, 12'h044, 32'h2, 32'h0, 1'h0},
    '{1'h1, 12'h048, 32'h2, 32'h0, 1'h0},
    '{1'h1, 12'h04C, 32'h1, 32'h0, 1'h0},
    '{1'h0, 12'h044, 32'h0, 32'h2, 1'h0},
    '{1'h1, 12'h0A0, 32'hFFFFFFFF, 32'h0, 1'h0},
    '{1'h0, 12'h0A0, 32'h0, 32'h1FF, 1'h0},
    '{1'h0, 12'h018, 32'h0, 32'h0, 1'h1},
    '{1'h1, 12'h002, 32'h5, 32'h0, 1'h1}
  };
  localparam rsc_out_type OUTS [7] = '{
    '{3'h0, 9'h130, 1'h0, 1'h0, 2'h3},
    '{3'h1, 9'h1B0, 1'h0, 1'h0, 2'h1},
    '{3'h2, 9'h170, 1'h0, 1'h0, 2'h0},
    '{3'h3, 9'h121, 1'h0, 1'h1, 2'h3},
    '{3'h4, 9'h110, 1'h0, 1'h0, 2'h1},
    '{3'h5, 9'h101, 1'h0, 1'h0, 2'h1},
    '{3'h7, 9'h130, 1'h1, 1'h0, 2'h0}
  };
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0, stop = 1'h0, run = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] seqh = 3'h0;
  logic [7:0] prim = 8'h00, so, soe;
  logic [3:0] flt = 4'h0, ocw = 4'h0, pwm, sync_rectifier_enable, rpg;
  logic pready, perr, err, pgood, ctrl, spg;
  int n_mismatch = 0, n_tests = 0, n;
  always #20 clk = ~clk;
  rsc_rail_seq DUT (.sys_clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(perr), .bus_stop_in(stop), .ctrl_pin_in(ctrl),
    .seq_pin_in({seqh, spg}), .pin_primary_in(prim), .fault_in(flt), .ocw_in(ocw),
    .pwm_en_out(pwm), .sync_rectifier_enable_out(sync_rectifier_enable), .rail_pg_out(rpg),
    .pgood_out(pgood), .seq_out(so), .seq_oe_out(soe));
  rsc_peer peer_m (.sys_clk_in(clk), .sys_rst_in(rst), .run_in(run), .pg_out(ctrl));
  rsc_peer peer_s (.sys_clk_in(clk), .sys_rst_in(rst), .run_in(pgood), .pg_out(spg));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // entered just after a rising edge; one idle cycle after, so no double drive
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    rd = prdata;
    err = perr;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
    if (k >= 50) n_mismatch++;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic wait_pg(input logic [3:0] m, input logic [3:0] v, input int lim);
    n = 0;
    while ((rpg & m) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    chk(32'({pwm, sync_rectifier_enable, rpg, pgood, soe}), 32'h0);
    rst <= 1'h0;
    @(posedge clk);
    foreach (ROWS[i]) begin
      apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
      chk(32'(err), 32'(ROWS[i].e));
      if (!ROWS[i].w) chk(rd, ROWS[i].q);
    end
    chk(32'(pwm), 32'h0);
    wr(12'h004, 32'h80);
    repeat (100) @(posedge clk);
    chk(32'(pwm[0]), 32'h0);
    wait_pg(4'h1, 4'h1, 12000);
    chk(32'(n > 7000 && n < 10000), 32'h1);
    wr(12'h004, 32'h0);
    repeat (3) @(posedge clk);
    chk(32'({rpg[0], pwm[0]}), 32'h1);
    repeat (8000) @(posedge clk);
    chk(32'(pwm), 32'h0);
    // page 255: one command for every rail; rail 0 is the slow one
    wr(12'h000, 32'hFF);
    wr(12'h004, 32'h80);
    wait_pg(4'hE, 4'hE, 6000);
    chk(32'(pgood), 32'h0);
    wait_pg(4'hF, 4'hF, 12000);
    repeat (2) @(posedge clk);
    chk(32'({rpg, pgood}), 32'h1F);
    wr(12'h010, 32'h2);
    wr(12'h004, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(pgood), 32'h0);
    repeat (8000) @(posedge clk);
    // every rail follows the control pin driven by the peer
    wr(12'h008, 32'h55);
    run <= 1'h1;
    wait_pg(4'h2, 4'h2, 6000);
    chk(32'(rpg[3:1]), 32'h7);
    run <= 1'h0;
    wait_pg(4'hE, 4'h0, 12000);
    chk(32'(rpg[3:1]), 32'h0);
    wr(12'h008, 32'hAA);
    wr(12'h000, 32'h1);
    wr(12'h00C, 32'h1);
    wr(12'h004, 32'h80);
    repeat (50) @(posedge clk);
    chk(32'(rpg[1]), 32'h0);
    stop <= 1'h1;
    @(posedge clk);
    stop <= 1'h0;
    wait_pg(4'h2, 4'h2, 6000);
    chk(32'(rpg[1]), 32'h1);
    wr(12'h00C, 32'h0);
    wr(12'h088, 32'h22);
    wr(12'h000, 32'h2);
    wr(12'h004, 32'h80);
    wait_pg(4'h4, 4'h4, 3000);
    chk(32'(rpg[2]), 32'h0);
    seqh <= 3'h1;
    wait_pg(4'h4, 4'h4, 6000);
    chk(32'(rpg[2]), 32'h1);
    // rail 1 fault is immediate and drags rail 3 down with it
    wr(12'h08C, 32'h200);
    wr(12'h084, 32'h2000);
    wr(12'h000, 32'h3);
    wr(12'h004, 32'h80);
    wait_pg(4'h8, 4'h8, 6000);
    flt <= 4'h2;
    repeat (3) @(posedge clk);
    chk(32'({pwm[3], pwm[1], sync_rectifier_enable[3]}), 32'h0);
    apb(1'h0, 12'h014, 32'h0);
    chk(32'(rd[5]), 32'h1);
    flt <= 4'h0;
    // timeout source is input 2, expected high, held low here
    wr(12'h00C, 32'hC);
    wr(12'h080, 32'h00021000);
    wr(12'h000, 32'h0);
    wr(12'h004, 32'h80);
    wait_pg(4'h1, 4'h1, 12000);
    wait_pg(4'h1, 4'h0, 8000);
    chk(32'(rpg[0]), 32'h0);
    apb(1'h0, 12'h014, 32'h0);
    chk(32'(rd[8]), 32'h1);
    wr(12'h014, 32'h100);
    apb(1'h0, 12'h014, 32'h0);
    chk(32'(rd[8]), 32'h0);
    foreach (OUTS[i]) begin
      prim <= OUTS[i].p ? (8'h01 << OUTS[i].n) : 8'h00;
      ocw <= {3'h0, OUTS[i].o};
      wr(12'h0A0 + {7'h0, OUTS[i].n, 2'h0}, {23'h0, OUTS[i].c});
      repeat (4) @(posedge clk);
      chk(32'({so[OUTS[i].n] & soe[OUTS[i].n], soe[OUTS[i].n]}), 32'(OUTS[i].x));
    end
    // mid-run reset: everything idles and the registers reload
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    chk(32'({pwm, sync_rectifier_enable, rpg, pgood, soe}), 32'h0);
    rst <= 1'h0;
    @(posedge clk);
    apb(1'h0, 12'h008, 32'h0);
    chk(rd, 32'hAA);
    chk(32'({pwm, rpg, pgood}), 32'h0);
    conclude;
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    conclude;
  end
endmodule
